// >>> rtl/spw_edge.sv
// Purpose: Trigger edge detector
// Assumes: Trigger is synchronous to the system clock
// Notes: Previous sample resets low so a high trigger at release is a rise
`timescale 1ns/100ps
module spw_edge
    import spw_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Trigger in, edges out
    input wire logic i_trig,
    spw_trig_if.src o_edges
);
    logic prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Previous sample
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= i_trig;
        end
    end

    // Compare with last sample
    assign o_edges.level = i_trig;
    assign o_edges.rise = i_trig & ~prev_reg;
    assign o_edges.fall = ~i_trig & prev_reg;
endmodule // spw_edge

// >>> rtl/spw_pkg.sv
// Purpose: Shared constants and types for the stairway pre-warning timer
// Assumes: One system clock at 25 MHz; timebase ticks arrive as a strobe
// Notes: Time values are counts of timebase ticks
package spw_pkg;
    localparam int SPW_TIME_W = 16;
    localparam logic [SPW_TIME_W-1:0] SPW_TIME_RST = 16'h0000;
    localparam logic SPW_OUT_RST = 1'b0;

    // Source selector for each time parameter
    typedef enum logic {
        SPW_SRC_CONST = 1'b0,
        SPW_SRC_LIVE = 1'b1
    } spw_src_t;

    // Operating state of the timer
    typedef enum logic [1:0] {
        SPW_IDLE = 2'b00,
        SPW_HOLD = 2'b01,
        SPW_RUN = 2'b10,
        SPW_PERM = 2'b11
    } spw_state_t;
endpackage

// >>> rtl/spw_timer.sv
// Purpose: Off-delay lighting timer, retriggerable in the simple variant, with pre-warning blink
// Assumes: i_tick pulses once per timebase unit; inputs synchronous
// Notes: Retained state lives in flip-flops that i_power_fail may spare
`timescale 1ns/100ps
module spw_timer
    import spw_pkg::*;
#(
    parameter int TW = SPW_TIME_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Timebase and power
    input wire logic i_tick,
    input wire logic i_power_fail,
    // Configuration
    input wire logic i_multi_mode,
    input wire logic i_retentive,
    input wire logic i_warn_en,
    input wire spw_src_t i_delay_src,
    input wire spw_src_t i_lead_src,
    input wire spw_src_t i_warn_len_src,
    input wire spw_src_t i_hold_src,
    input wire logic [TW-1:0] i_delay_const,
    input wire logic [TW-1:0] i_delay_live,
    input wire logic [TW-1:0] i_lead_const,
    input wire logic [TW-1:0] i_lead_live,
    input wire logic [TW-1:0] i_warn_len_const,
    input wire logic [TW-1:0] i_warn_len_live,
    input wire logic [TW-1:0] i_hold_const,
    input wire logic [TW-1:0] i_hold_live,
    // Switch side
    input wire logic i_trig,
    input wire logic i_clear,
    // Lamp side and status
    output logic o_lamp,
    output logic [TW-1:0] o_elapsed_time,
    output logic o_perm_light
);
    spw_trig_if trig_bus ();
    spw_state_t state_reg, state_next;
    logic [TW-1:0] elapsed_time_reg, elapsed_time_next;
    logic lamp_reg, lamp_next;

    ////////////////////////////////////////////////////////////////////////
    // Parameter source selection
    function automatic logic [TW-1:0] pick(input spw_src_t s, input logic [TW-1:0] c,
                                           input logic [TW-1:0] l);
        pick = (s == SPW_SRC_LIVE) ? l : c;
    endfunction

    wire [TW-1:0] delay_w = pick(i_delay_src, i_delay_const, i_delay_live);
    wire [TW-1:0] lead_w = pick(i_lead_src, i_lead_const, i_lead_live);
    wire [TW-1:0] wlen_w = pick(i_warn_len_src, i_warn_len_const, i_warn_len_live);
    wire [TW-1:0] permanent_hold_time = pick(i_hold_src, i_hold_const, i_hold_live);

    spw_edge u_edge (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_trig(i_trig),
        .o_edges(trig_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decodes; all times share one tick base
    wire [TW:0] warn_start_w = {1'b0, delay_w} - {1'b0, lead_w};
    wire [TW:0] warn_end_w = warn_start_w + {1'b0, wlen_w};
    wire [TW:0] et_w = {1'b0, elapsed_time_reg};
    wire in_warn_w = i_warn_en && !warn_start_w[TW] && (et_w >= warn_start_w)
                     && (et_w < warn_end_w);
    wire expired_w = (elapsed_time_reg == delay_w);
    wire clear_w = i_multi_mode && i_clear;
    // Simple variant restarts on either edge; multi uses rises as toggles
    wire retrig_w = !i_multi_mode && (trig_bus.rise || trig_bus.fall);
    wire et_step_w = i_tick && (elapsed_time_reg != {TW{1'b1}});

    // Next-state decision
    always_comb begin
        state_next = state_reg;
        elapsed_time_next = elapsed_time_reg;
        unique case (state_reg)
            SPW_IDLE: begin
                if (trig_bus.rise) begin
                    elapsed_time_next = SPW_TIME_RST;
                    state_next = i_multi_mode ? SPW_HOLD : SPW_RUN;
                end
            end
            SPW_HOLD: begin
                if (!trig_bus.level) begin
                    elapsed_time_next = SPW_TIME_RST;
                    state_next = SPW_RUN;
                end else if (elapsed_time_reg >= permanent_hold_time) begin
                    elapsed_time_next = SPW_TIME_RST;
                    state_next = SPW_PERM;
                end else if (et_step_w) begin
                    elapsed_time_next = elapsed_time_reg + 1'b1;
                end
            end
            SPW_RUN: begin
                if (i_multi_mode && trig_bus.rise) begin
                    elapsed_time_next = SPW_TIME_RST;
                    state_next = SPW_IDLE;
                end else if (retrig_w) begin
                    elapsed_time_next = SPW_TIME_RST;
                end else if (expired_w) begin
                    state_next = SPW_IDLE;
                end else if (et_step_w) begin
                    elapsed_time_next = elapsed_time_reg + 1'b1;
                end
            end
            SPW_PERM: begin
                if (trig_bus.rise) begin
                    elapsed_time_next = SPW_TIME_RST;
                    state_next = SPW_IDLE;
                end
            end
        endcase
        if (clear_w) begin
            elapsed_time_next = SPW_TIME_RST;
            state_next = SPW_IDLE;
        end
    end

    // Lamp follows state, dark during the warning gap and from expiry on
    wire run_next_w = (state_next == SPW_RUN) && (state_reg == SPW_RUN) && !retrig_w;
    wire warn_dark_w = run_next_w && in_warn_w;
    wire expire_dark_w = run_next_w && (elapsed_time_next == delay_w);
    assign lamp_next = (state_next == SPW_HOLD) || (state_next == SPW_PERM)
                       || ((state_next == SPW_RUN) && !warn_dark_w && !expire_dark_w);

    ////////////////////////////////////////////////////////////////////////
    // State registers, spared by power fail when retentive
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || (i_power_fail && !i_retentive)) begin
            state_reg <= SPW_IDLE;
            elapsed_time_reg <= SPW_TIME_RST;
            lamp_reg <= SPW_OUT_RST;
        end else if (!i_power_fail) begin
            state_reg <= state_next;
            elapsed_time_reg <= elapsed_time_next;
            lamp_reg <= lamp_next;
        end
    end

    assign o_lamp = lamp_reg;
    assign o_elapsed_time = elapsed_time_reg;
    assign o_perm_light = (state_reg == SPW_PERM);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_rise_sets_lamp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_IDLE && trig_bus.rise && !clear_w && !i_power_fail)
        |=> o_lamp)
        else $error("lamp not set by trigger rise");
    a_clear_drops_lamp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (clear_w && !i_power_fail) |=> (!o_lamp && o_elapsed_time == '0))
        else $error("clear did not drop lamp");
    a_simple_ignores_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_multi_mode && i_clear && state_reg == SPW_RUN && !trig_bus.rise
         && !trig_bus.fall && !expired_w && !i_power_fail) |=> (state_reg == SPW_RUN))
        else $error("simple variant reacted to clear");
    a_fall_restart: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_multi_mode && state_reg == SPW_RUN && trig_bus.fall && !i_power_fail)
        |=> (o_elapsed_time == '0 && o_lamp))
        else $error("fall did not restart elapsed time");
    a_expire_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_RUN && expired_w && !trig_bus.rise && !trig_bus.fall
         && !i_power_fail) |=> (state_reg == SPW_IDLE && !o_lamp))
        else $error("timer did not expire");
    a_multi_toggle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_multi_mode && state_reg == SPW_PERM && trig_bus.rise && !i_power_fail)
        |=> !o_lamp)
        else $error("permanent light not toggled off");
    a_nonret_fail: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_power_fail && !i_retentive) |=> (!o_lamp && o_elapsed_time == '0))
        else $error("power fail did not zero state");
    a_ret_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_power_fail && i_retentive) |=> ($stable(o_lamp) && $stable(o_elapsed_time)))
        else $error("retained state changed");
    a_tick_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_RUN && i_tick && !expired_w && !trig_bus.rise && !trig_bus.fall
         && !clear_w && !i_power_fail && elapsed_time_reg != '1)
        |=> (o_elapsed_time == $past(o_elapsed_time) + 1'b1))
        else $error("elapsed time did not step");
    // Restart, warning and long-press checks
    a_rise_restart: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_multi_mode && state_reg == SPW_RUN && trig_bus.rise && !i_power_fail)
        |=> (o_elapsed_time == '0 && o_lamp))
        else $error("further trigger did not restart");
    a_warn_gap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_RUN && in_warn_w && !retrig_w && !clear_w && !i_power_fail)
        |=> !o_lamp)
        else $error("pre-warning gap missing");
    a_multi_rise_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_multi_mode && state_reg == SPW_IDLE && trig_bus.rise && !clear_w && !i_power_fail)
        |=> (state_reg == SPW_HOLD && o_lamp))
        else $error("multi-function rise did not start hold");
    a_hold_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_HOLD && trig_bus.level && elapsed_time_reg >= permanent_hold_time
         && !clear_w && !i_power_fail) |=> (o_perm_light && o_lamp))
        else $error("long press did not latch");
    a_early_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state_reg == SPW_HOLD && !trig_bus.level && !clear_w && !i_power_fail)
        |=> (state_reg == SPW_RUN && o_elapsed_time == '0 && o_lamp))
        else $error("early release did not start off-delay");
    a_run_toggle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_multi_mode && state_reg == SPW_RUN && trig_bus.rise && !i_power_fail)
        |=> (!o_lamp && o_elapsed_time == '0))
        else $error("running timer not toggled off");
endmodule // spw_timer

// >>> rtl/spw_trig_if.sv
// Purpose: Carries trigger samples and detected edges between modules
// Assumes: Single clock domain
// Notes: Edge strobes last one cycle
`timescale 1ns/100ps
interface spw_trig_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// >>> verification/spw_switch_model.sv
// Purpose: Wall switch and lamp load facing the timer
// Assumes: Switch moves by non-blocking assignment at a rising edge
// Notes: The lamp load integrates its lit cycles
`timescale 1ns/100ps
module spw_switch_model (
    // Clock
    input wire logic i_sys_clk,
    // Switch out, lamp in
    output logic o_trig,
    input wire logic i_lamp
);
    int lit_cycles = 0;
    initial o_trig = 1'b0;
    // Lamp on-time tally
    always @(posedge i_sys_clk) lit_cycles <= lit_cycles + int'(i_lamp);
    // Hold the switch closed for n cycles, then open it
    task automatic press(input int n);
        @(posedge i_sys_clk) o_trig <= 1'b1;
        repeat (n) @(posedge i_sys_clk);
        o_trig <= 1'b0;
    endtask
endmodule // spw_switch_model

// >>> verification/tb.sv
// Purpose: Self-checking bench for the stairway pre-warning timer
// Assumes: Tick strobes every cycle except in the freeze test
// Notes: Short time values keep the run brief
`timescale 1ns/100ps
module tb
    import spw_pkg::*;
;
    logic clk = 0, rst = 1, tick = 1, pf = 0, multi = 0, ret = 0, warn = 0, clr = 0;
    spw_src_t dsrc = SPW_SRC_CONST;
    logic [15:0] cdly = 16'h0006, clead = 16'h0004, clen = 16'h0002, chold = 16'h0004;
    logic [15:0] dlive = 16'h0000, llead = 16'h0000, llen = 16'h0000, lhold = 16'h0005;
    logic [15:0] elap;
    logic lamp, perm, trig;
    int checked = 0, mismatches = 0, cyc = 0, waited, lit0;
    ////////////////////////////////////////////////////////////////
    spw_switch_model spw_switch_model_i (.i_sys_clk(clk), .o_trig(trig), .i_lamp(lamp));
    spw_timer spw_timer_i (.i_sys_clk(clk), .i_rst(rst), .i_tick(tick), .i_power_fail(pf),
        .i_multi_mode(multi), .i_retentive(ret), .i_warn_en(warn), .i_delay_src(dsrc),
        .i_lead_src(dsrc), .i_warn_len_src(dsrc), .i_hold_src(dsrc),
        .i_delay_const(cdly), .i_delay_live(dlive), .i_lead_const(clead),
        .i_lead_live(llead), .i_warn_len_const(clen), .i_warn_len_live(llen),
        .i_hold_const(chold), .i_hold_live(lhold), .i_trig(trig), .i_clear(clr),
        .o_lamp(lamp), .o_elapsed_time(elap), .o_perm_light(perm));
    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // Shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_lamp(input logic v);
        waited = 0;
        do begin
            step(1);
            waited++;
        end while (lamp !== v && waited < 60);
        if (lamp !== v) begin
            mismatches++;
            $display("[ERR] t=%0t lamp wait timed out seen=%h exp=%h", $time, lamp, v);
        end
    endtask
    task automatic pulse_clr();
        @(posedge clk) clr <= 1;
        @(posedge clk) clr <= 0;
        step(1);
    endtask
    task automatic pfail();
        @(posedge clk) pf <= 1;
        repeat (3) @(posedge clk);
        pf <= 0;
        step(1);
    endtask
    task automatic final_report();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        // Simple variant: set, restart on fall, retrigger, expiry
        spw_switch_model_i.press(1);
        #1;
        check(lamp, 1);
        step(1);
        check(elap, 0);
        step(3);
        check(elap, 3);
        // Tick held low freezes elapsed time
        @(posedge clk) tick <= 0;
        step(3);
        check(elap, 16'h0004);
        @(posedge clk) tick <= 1;
        spw_switch_model_i.press(1);
        #1;
        check(elap, 0);
        wait_lamp(0);
        check(elap, cdly);
        // Live parameters with pre-warning gap
        @(posedge clk) dsrc <= SPW_SRC_LIVE;
        warn <= 1;
        dlive <= 16'h000a;
        llead <= 16'h0005;
        llen <= 16'h0003;
        spw_switch_model_i.press(2);
        wait_lamp(0);
        check(elap, dlive - llead + 16'h0001);
        wait_lamp(1);
        check(waited[15:0], llen);
        wait_lamp(0);
        check(elap, dlive);
        // Multiple-function variant
        @(posedge clk) dsrc <= SPW_SRC_CONST;
        warn <= 0;
        multi <= 1;
        spw_switch_model_i.press(2);
        #1;
        check(lamp, 1);
        wait_lamp(0);
        check(elap, cdly);
        spw_switch_model_i.press(8);
        #1;
        check(perm, 1);
        lit0 = spw_switch_model_i.lit_cycles;
        step(20);
        check(lamp, 1);
        check(16'(spw_switch_model_i.lit_cycles - lit0), 16'h0014);
        spw_switch_model_i.press(1);
        step(1);
        check(lamp, 0);
        check(perm, 0);
        // Second trigger while the off-delay runs turns the lamp off
        spw_switch_model_i.press(1);
        spw_switch_model_i.press(1);
        step(1);
        check(lamp, 0);
        check(elap, 0);
        spw_switch_model_i.press(1);
        pulse_clr();
        check(lamp, 0);
        check(elap, 0);
        // Clear ignored in the simple variant
        @(posedge clk) multi <= 0;
        spw_switch_model_i.press(1);
        pulse_clr();
        check(lamp, 1);
        wait_lamp(0);
        // Power loss with and without retention
        @(posedge clk) ret <= 1;
        spw_switch_model_i.press(1);
        pfail();
        check(lamp, 1);
        check(elap, 16'h0001);
        wait_lamp(0);
        @(posedge clk) ret <= 0;
        spw_switch_model_i.press(1);
        pfail();
        check(lamp, 0);
        check(elap, 0);
        final_report();
    end
endmodule // tb
